// >>> core/pdn_regs_pkg.sv
// Purpose: Shared constants and types for the output-buffer and
//          power-down register bank.
// Assumes: Core clock of 125 MHz; serial port pins sampled on it.
// Notes:   Frame is 16 bits, MSB first: read flag, 7-bit address, data.
package pdn_regs_pkg;

  // ---------------------------------------------------------------
  // Clock and frame geometry
  // ---------------------------------------------------------------
  localparam int          CLK_MHZ       = 125;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 8;
  localparam logic [4:0]  HDR_BITS      = 5'h08;
  localparam logic [4:0]  FRAME_BITS    = 5'h10;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0]  ADDR_PWR_CTL  = 7'h08;
  localparam logic [6:0]  ADDR_OFF_HIGH = 7'h0A;
  localparam logic [6:0]  ADDR_OFF_MID  = 7'h0B;
  localparam logic [6:0]  ADDR_OFF_LOW  = 7'h0C;
  localparam logic [6:0]  ADDR_PD_MASK  = 7'h0D;
  localparam logic [6:0]  ADDR_SYNC_REF = 7'h0E;
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          BIT_SLEEP_REQ   = 0; // power control reg
  localparam int          BIT_KEEP_CLKBUF = 3; // mask reg
  localparam int          BIT_KEEP_REFAMP = 2;
  localparam int          BIT_BG_OFF      = 1;
  localparam int          BIT_PIN_IS_SYNC = 7; // sync/ref reg
  localparam int          BIT_REG_SYNC    = 6;
  localparam int          BIT_REG_SYNC_EN = 5;
  localparam int          BIT_REF_BY_REG  = 3;
  localparam int          REF_SEL_HI      = 2;
  localparam int          REF_SEL_LO      = 1;
  localparam int          BIT_SE_CLOCK    = 0;

  // Write strobe with its address and data
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_write_t;

endpackage : pdn_regs_pkg

// >>> core/serial_port.sv
// Purpose: Serial control port slave; turns 16-bit frames into
//          register writes and shifts read data back out.
// Assumes: All pins synchronous to clk; sclk far slower than clk.
// Notes:   Data in on sclk rising edge, data out on falling edge.
`timescale 1ns/1ps
module serial_port
  import pdn_regs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              sclk,
  input  wire logic              sen_n,
  input  wire logic              sdi,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic      [ADDR_W-1:0] rd_addr,
  output reg_write_t             wr_out,
  output logic                   sdo,
  output logic                   sdo_oe
);

  typedef struct packed {
    logic              sclk_prev;
    logic [15:0]       shift;
    logic [4:0]        cnt;
    logic              is_read;
    logic [DATA_W-1:0] out_shift;
    logic              sdo;
    logic              sdo_oe;
    reg_write_t        wr;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;

  logic rise;
  logic fall;

  assign rise    = sclk & ~st_r.sclk_prev;
  assign fall    = ~sclk & st_r.sclk_prev;
  assign rd_addr = st_r.shift[ADDR_W-1:0];
  assign wr_out  = st_r.wr;
  assign sdo     = st_r.sdo;
  assign sdo_oe  = st_r.sdo_oe;

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.sclk_prev = sclk;
    st_nxt.wr.wr     = 1'b0;                 // Strobe lasts one cycle
    if (sen_n) begin
      // Deselect aborts any partial frame; nothing is written
      st_nxt.cnt    = 5'h00;
      st_nxt.sdo_oe = 1'b0;
      st_nxt.sdo    = 1'b0;
    end else begin
      if (rise && st_r.cnt < FRAME_BITS) begin
        st_nxt.shift = {st_r.shift[14:0], sdi};
        st_nxt.cnt   = st_r.cnt + 5'h01;
        if (st_r.cnt == 5'h00) begin
          st_nxt.is_read = sdi;
        end
        if (st_r.cnt == FRAME_BITS - 5'h01 && !st_r.is_read) begin
          st_nxt.wr.wr   = 1'b1;
          // Address sits just below the read flag after 15 shifts
          st_nxt.wr.addr = st_r.shift[DATA_W+ADDR_W-2 -: ADDR_W];
          st_nxt.wr.data = {st_r.shift[6:0], sdi};
        end
      end
      // Read data goes out after the header, one bit per fall
      if (fall && st_r.is_read && st_r.cnt == HDR_BITS) begin
        st_nxt.sdo       = rd_data[DATA_W-1];
        st_nxt.out_shift = {rd_data[DATA_W-2:0], 1'b0};
        st_nxt.sdo_oe    = 1'b1;
      end else if (fall && st_r.sdo_oe && st_r.cnt < FRAME_BITS) begin
        st_nxt.sdo       = st_r.out_shift[DATA_W-1];
        st_nxt.out_shift = {st_r.out_shift[DATA_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : serial_port

// >>> core/output_buffer_power_down_regs.sv
// Purpose: Output-driver power-down bits, global power-down mask,
//          sync and reference-selection controls.
// Assumes: Host reaches the bank over the serial control port.
// Notes:   Every output is a flip-flop; wake time is modelled as a
//          busy flag whose length depends on the bandgap setting.
`timescale 1ns/1ps

// Behaviour
// - Each set bit powers down one output driver
// - Off bits never touch data clock buffers
// - Mask bit 3 keeps clock buffer running
// - Mask bit 2 keeps reference amplifier running
// - Mask bit 1 set turns bandgap off
// - Bandgap off saves power, wakes slower
// - Sleep request powers down masked blocks
// - Bit 7 picks sleep or sync pin meaning
// - Enabled bit 6 write issues sync; not self-clearing
// - Bits 2:1 select reference; code 11 unused
module output_buffer_power_down_regs
  import pdn_regs_pkg::*;
#(
  parameter int WAKE_FAST_NS = 1000,
  parameter int WAKE_SLOW_NS = 100000
) (
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_SEN_N,
  input  wire logic        SPI_SDI,
  output logic             SPI_SDO,
  output logic             SPI_SDO_OE,
  input  wire logic        SHARED_SYNC_SLEEP_PIN,
  output logic [23:0]      OUTPUT_DRIVER_OFF,
  output logic             SLEEP_ACTIVE,
  output logic             SAMPLE_CLOCK_BUFFER_OFF,
  output logic             REFERENCE_AMPLIFIER_OFF,
  output logic             BANDGAP_OFF,
  output logic             WAKE_BUSY,
  output logic             SYNC_PULSE,
  output logic             REFERENCE_SOURCE_BY_REGISTER,
  output logic [1:0]       REFERENCE_SELECT,
  output logic             SINGLE_ENDED_CLOCK_SELECT
);

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Least times, rounded up to whole cycles
  localparam int WAKE_FAST_CYC = (WAKE_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_SLOW_CYC = (WAKE_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam logic [23:0] WAKE_FAST_CNT = 24'(WAKE_FAST_CYC);
  localparam logic [23:0] WAKE_SLOW_CNT = 24'(WAKE_SLOW_CYC);

  typedef struct packed {
    logic [7:0]  pwr_ctl;
    logic [7:0]  off_high;
    logic [7:0]  off_mid;
    logic [7:0]  off_low;
    logic [7:0]  pd_mask;
    logic [7:0]  sync_ref;
    logic        pin_prev;
    logic        sleep;
    logic        clkbuf_off;
    logic        refamp_off;
    logic        bg_off;
    logic [23:0] wake_cnt;
    logic        wake_busy;
    logic        sync_pulse;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;

  reg_write_t  wr;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        sdo;
  logic        sdo_oe;
  logic        sleep_now;

  // ---------------------------------------------------------------
  // Serial control port
  // ---------------------------------------------------------------
  serial_port u_port (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .sclk    (SPI_SCLK),
    .sen_n   (SPI_SEN_N),
    .sdi     (SPI_SDI),
    .rd_data (rd_data),
    .rd_addr (rd_addr),
    .wr_out  (wr),
    .sdo     (sdo),
    .sdo_oe  (sdo_oe)
  );

  // Read mux; unmapped addresses read as zero
  function automatic logic [7:0] read_reg(input bank_state_t s,
                                          input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_PWR_CTL) begin
      v = s.pwr_ctl;
    end else if (a == ADDR_OFF_HIGH) begin
      v = s.off_high;
    end else if (a == ADDR_OFF_MID) begin
      v = s.off_mid;
    end else if (a == ADDR_OFF_LOW) begin
      v = s.off_low;
    end else if (a == ADDR_PD_MASK) begin
      v = s.pd_mask;
    end else if (a == ADDR_SYNC_REF) begin
      v = s.sync_ref;
    end
    return v;
  endfunction : read_reg

  assign rd_data = read_reg(st_r, rd_addr);

  // ---------------------------------------------------------------
  // Register writes and power-down control
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt            = st_r;
    st_nxt.pin_prev   = SHARED_SYNC_SLEEP_PIN;
    st_nxt.sync_pulse = 1'b0;
    // All bits are stored whole, reserved ones included, except power control, which keeps only the sleep request bit
    if (wr.wr) begin
      if (wr.addr == ADDR_PWR_CTL) begin
        st_nxt.pwr_ctl = wr.data & (8'h01 << BIT_SLEEP_REQ);
      end else if (wr.addr == ADDR_OFF_HIGH) begin
        st_nxt.off_high = wr.data;
      end else if (wr.addr == ADDR_OFF_MID) begin
        st_nxt.off_mid = wr.data;
      end else if (wr.addr == ADDR_OFF_LOW) begin
        st_nxt.off_low = wr.data;
      end else if (wr.addr == ADDR_PD_MASK) begin
        st_nxt.pd_mask = wr.data;
      end else if (wr.addr == ADDR_SYNC_REF) begin
        st_nxt.sync_ref = wr.data;
        // An enabled 0 to 1 write of the sync bit fires once; it stays set
        if (wr.data[BIT_REG_SYNC] && !st_r.sync_ref[BIT_REG_SYNC] &&
            wr.data[BIT_REG_SYNC_EN]) begin
          st_nxt.sync_pulse = 1'b1;
        end
      end
    end
    // Pin rising edge issues sync when assigned to it
    if (SHARED_SYNC_SLEEP_PIN && !st_r.pin_prev &&
        st_nxt.sync_ref[BIT_PIN_IS_SYNC]) begin
      st_nxt.sync_pulse = 1'b1;
    end
    // Pin means sleep only while not assigned to sync; built here from
    // the new register values so no loop runs through a continuous
    // assignment back into this process
    sleep_now = st_nxt.pwr_ctl[BIT_SLEEP_REQ] |
                (SHARED_SYNC_SLEEP_PIN &
                 ~st_nxt.sync_ref[BIT_PIN_IS_SYNC]);
    st_nxt.sleep      = sleep_now;
    st_nxt.clkbuf_off = sleep_now &
                        ~st_nxt.pd_mask[BIT_KEEP_CLKBUF];
    st_nxt.refamp_off = sleep_now &
                        ~st_nxt.pd_mask[BIT_KEEP_REFAMP];
    // Inverted sense: a set bit lets the bandgap go down
    st_nxt.bg_off     = sleep_now &
                        st_nxt.pd_mask[BIT_BG_OFF];
    // Wake time is longer if the bandgap was down; re-sleep aborts it
    if (sleep_now) begin
      st_nxt.wake_busy = 1'b0;
      st_nxt.wake_cnt  = 24'h000000;
    end else if (st_r.sleep) begin
      st_nxt.wake_busy = 1'b1;
      st_nxt.wake_cnt  = st_r.bg_off ? WAKE_SLOW_CNT
                                     : WAKE_FAST_CNT;
    end else if (st_r.wake_cnt > 24'h000001) begin
      st_nxt.wake_cnt  = st_r.wake_cnt - 24'h000001;
    end else begin
      st_nxt.wake_cnt  = 24'h000000;
      st_nxt.wake_busy = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r          <= '0;
      st_r.pwr_ctl  <= REG_RESET;
      st_r.off_high <= REG_RESET;
      st_r.off_mid  <= REG_RESET;
      st_r.off_low  <= REG_RESET;
      st_r.pd_mask  <= REG_RESET;
      st_r.sync_ref <= REG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Driver-off bits only; data clock buffers are controlled elsewhere
  assign OUTPUT_DRIVER_OFF = {st_r.off_high, st_r.off_mid,
                              st_r.off_low};
  assign SLEEP_ACTIVE            = st_r.sleep;
  assign SAMPLE_CLOCK_BUFFER_OFF = st_r.clkbuf_off;
  assign REFERENCE_AMPLIFIER_OFF = st_r.refamp_off;
  assign BANDGAP_OFF             = st_r.bg_off;
  assign WAKE_BUSY               = st_r.wake_busy;
  assign SYNC_PULSE              = st_r.sync_pulse;
  assign SPI_SDO                 = sdo;
  assign SPI_SDO_OE              = sdo_oe;
  assign REFERENCE_SOURCE_BY_REGISTER = st_r.sync_ref[BIT_REF_BY_REG];
  // Code 11 is passed through; it selects nothing in the analog
  assign REFERENCE_SELECT = st_r.sync_ref[REF_SEL_HI:REF_SEL_LO];
  assign SINGLE_ENDED_CLOCK_SELECT = st_r.sync_ref[BIT_SE_CLOCK];

endmodule : output_buffer_power_down_regs

// >>> test/pdn_regs_monitor.sv
// Purpose: Port-level checker for the power-down register bank.
// Assumes: Bound to the top module; one clock domain.
// Notes:   Register-driven outputs move only 2-3 cycles after a frame's last SCLK rise, while SEN_N is still low.
`timescale 1ns/1ps
module pdn_regs_monitor
  import pdn_regs_pkg::*;
#(
  parameter int WAKE_FAST_NS = 1000,
  parameter int WAKE_SLOW_NS = 100000
) (
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  input wire logic        SPI_SEN_N,
  input wire logic        SPI_SDO_OE,
  input wire logic        SHARED_SYNC_SLEEP_PIN,
  input wire logic [23:0] OUTPUT_DRIVER_OFF,
  input wire logic        SLEEP_ACTIVE,
  input wire logic        SAMPLE_CLOCK_BUFFER_OFF,
  input wire logic        REFERENCE_AMPLIFIER_OFF,
  input wire logic        BANDGAP_OFF,
  input wire logic        WAKE_BUSY,
  input wire logic        SYNC_PULSE,
  input wire logic [1:0]  REFERENCE_SELECT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // -------------------------------------------------------------
  // Helper logic
  // -------------------------------------------------------------
  logic [15:0] busy_cnt_r;

  // Length of the running wake period, cleared when idle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) busy_cnt_r <= 16'h0000;
    else busy_cnt_r <= WAKE_BUSY ? busy_cnt_r + 16'h0001 : 16'h0000;
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  a_clkbuf_in_sleep: assert property (
    SAMPLE_CLOCK_BUFFER_OFF |-> SLEEP_ACTIVE) else $error("clkbuf off");
  a_refamp_in_sleep: assert property (
    REFERENCE_AMPLIFIER_OFF |-> SLEEP_ACTIVE) else $error("refamp off");
  a_bandgap_in_sleep: assert property (
    BANDGAP_OFF |-> SLEEP_ACTIVE) else $error("bandgap off");
  a_wake_starts: assert property (
    $fell(SLEEP_ACTIVE) |-> ##[0:1] WAKE_BUSY) else $error("no wake");
  a_sleep_clears_wake: assert property (
    $rose(SLEEP_ACTIVE) |-> ##[0:1] !WAKE_BUSY) else $error("busy");
  a_wake_bounded: assert property (
    busy_cnt_r <= 16'(WAKE_SLOW_NS / 8 + 2)) else $error("wake long");
  a_sync_single: assert property (
    SYNC_PULSE |=> !SYNC_PULSE) else $error("sync pulse long");
  a_sync_cause: assert property (
    SYNC_PULSE |-> $past(SHARED_SYNC_SLEEP_PIN) || $past(!SPI_SEN_N, 2)
      || $past(!SPI_SEN_N, 3)) else $error("sync without cause");
  a_drv_by_write: assert property (
    $changed(OUTPUT_DRIVER_OFF) |-> $past(!SPI_SEN_N, 2))
    else $error("driver bits moved");
  a_ref_by_write: assert property (
    $changed(REFERENCE_SELECT) |-> $past(!SPI_SEN_N, 2)
      || $past(!SPI_SEN_N, 3)) else $error("reference moved");
  a_oe_in_frame: assert property (
    SPI_SDO_OE |-> $past(!SPI_SEN_N)) else $error("oe out of frame");

  c_sleep: cover property ($rose(SLEEP_ACTIVE));
  c_sync: cover property (SYNC_PULSE);
  c_bandgap: cover property (BANDGAP_OFF);
endmodule : pdn_regs_monitor

bind output_buffer_power_down_regs pdn_regs_monitor #(
  .WAKE_FAST_NS(WAKE_FAST_NS), .WAKE_SLOW_NS(WAKE_SLOW_NS)) mon (
  .CORE_CLK, .ARST_N, .SPI_SEN_N, .SPI_SDO_OE, .SHARED_SYNC_SLEEP_PIN,
  .OUTPUT_DRIVER_OFF, .SLEEP_ACTIVE, .SAMPLE_CLOCK_BUFFER_OFF,
  .REFERENCE_AMPLIFIER_OFF, .BANDGAP_OFF, .WAKE_BUSY, .SYNC_PULSE,
  .REFERENCE_SELECT);

// >>> test/output_buffer_power_down_regs_tb.sv
// Purpose: Self-checking bench for the power-down register bank.
// Assumes: Short wake times of 400/1600 ns (50/200 cycles).
// Notes:   SCLK levels last 3 core cycles, well above the minimum.
`timescale 1ns/1ps
module output_buffer_power_down_regs_tb
  import pdn_regs_pkg::*;
;
  logic        CORE_CLK = 1'b0, ARST_N = 1'b0, SPI_SCLK = 1'b0;
  logic        SPI_SEN_N = 1'b1, SPI_SDI = 1'b0, SPI_SDO, SPI_SDO_OE;
  logic        SHARED_SYNC_SLEEP_PIN = 1'b0, SLEEP_ACTIVE, WAKE_BUSY;
  logic        SAMPLE_CLOCK_BUFFER_OFF, REFERENCE_AMPLIFIER_OFF;
  logic        BANDGAP_OFF, SYNC_PULSE, REFERENCE_SOURCE_BY_REGISTER;
  logic        SINGLE_ENDED_CLOCK_SELECT;
  logic [23:0] OUTPUT_DRIVER_OFF;
  logic [1:0]  REFERENCE_SELECT;
  logic [7:0]  q, m;
  logic [23:0] modes [4] = '{24'h2346F0, 24'h7FEEFC, 24'hFFEEFD,
                             24'hFFEFFD};
  logic [7:0]  masks [4] = '{8'hF1, 8'h0E, 8'h08, 8'h06};
  logic [7:0]  syncs [6] = '{8'h40, 8'h20, 8'h60, 8'h60, 8'h20, 8'h60};
  int          bad_count = 0, samples_checked = 0, pulses = 0, n, p;

  output_buffer_power_down_regs #(.WAKE_FAST_NS(400), .WAKE_SLOW_NS(1600))
    DUT (
    .CORE_CLK                     (CORE_CLK),
    .ARST_N                       (ARST_N),
    .SPI_SCLK                     (SPI_SCLK),
    .SPI_SEN_N                    (SPI_SEN_N),
    .SPI_SDI                      (SPI_SDI),
    .SPI_SDO                      (SPI_SDO),
    .SPI_SDO_OE                   (SPI_SDO_OE),
    .SHARED_SYNC_SLEEP_PIN        (SHARED_SYNC_SLEEP_PIN),
    .OUTPUT_DRIVER_OFF            (OUTPUT_DRIVER_OFF),
    .SLEEP_ACTIVE                 (SLEEP_ACTIVE),
    .SAMPLE_CLOCK_BUFFER_OFF      (SAMPLE_CLOCK_BUFFER_OFF),
    .REFERENCE_AMPLIFIER_OFF      (REFERENCE_AMPLIFIER_OFF),
    .BANDGAP_OFF                  (BANDGAP_OFF),
    .WAKE_BUSY                    (WAKE_BUSY),
    .SYNC_PULSE                   (SYNC_PULSE),
    .REFERENCE_SOURCE_BY_REGISTER (REFERENCE_SOURCE_BY_REGISTER),
    .REFERENCE_SELECT             (REFERENCE_SELECT),
    .SINGLE_ENDED_CLOCK_SELECT    (SINGLE_ENDED_CLOCK_SELECT)
  );

  // Free-running core clock and sync pulse tally
  always #4 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) if (SYNC_PULSE === 1'b1) pulses <= pulses + 1;

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task tick(input int c);
    repeat (c) @(posedge CORE_CLK);
    #1;
  endtask : tick

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check

  // One 16-bit frame; read data captured at the last 8 SCLK rises
  task spi(input logic rd, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rd, a, d};
    SPI_SEN_N = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      SPI_SDI = f[i];
      tick(3);
      SPI_SCLK = 1'b1;
      if (i < 8) q[i] = SPI_SDO;
      tick(3);
      SPI_SCLK = 1'b0;
    end
    tick(3);
    SPI_SEN_N = 1'b1;
    SPI_SDI = ~SPI_SDI; // Line released: do not leave the last bit
    tick(2);
  endtask : spi

  task wr(input logic [6:0] a, input logic [7:0] d);
    spi(1'b0, a, d);
  endtask : wr

  task rd_chk(input logic [6:0] a, input logic [7:0] e);
    spi(1'b1, a, 8'h00);
    check(q, e);
  endtask : rd_chk

  task wake_len(output int c);
    c = 0;
    while (WAKE_BUSY === 1'b1 && c < 1000) begin
      tick(1);
      c++;
    end
  endtask : wake_len

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Watchdog at about four times the expected run of 6.5k cycles
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    tick(16);
    ARST_N = 1'b1;
    tick(3);
    for (int r = 10; r <= 14; r++) rd_chk(7'(r), 8'h00);
    // Recommended settings per output mode, then read back
    foreach (modes[i]) begin
      wr(ADDR_OFF_HIGH, modes[i][23:16]);
      wr(ADDR_OFF_MID, modes[i][15:8]);
      wr(ADDR_OFF_LOW, modes[i][7:0]);
      check(OUTPUT_DRIVER_OFF, modes[i]);
      rd_chk(ADDR_OFF_HIGH, modes[i][23:16]);
      rd_chk(ADDR_OFF_MID, modes[i][15:8]);
      rd_chk(ADDR_OFF_LOW, modes[i][7:0]);
      check(OUTPUT_DRIVER_OFF[19], i > 0);
      check({SAMPLE_CLOCK_BUFFER_OFF, SLEEP_ACTIVE}, 0);
    end
    wr(7'h0F, 8'h5A);
    rd_chk(7'h0F, 8'h00);
    // Mask variants through a sleep and wake cycle
    foreach (masks[k]) begin
      m = masks[k];
      wr(ADDR_PD_MASK, m);
      rd_chk(ADDR_PD_MASK, m);
      wr(ADDR_PWR_CTL, 8'h01);
      check({SAMPLE_CLOCK_BUFFER_OFF, REFERENCE_AMPLIFIER_OFF, BANDGAP_OFF,
             SLEEP_ACTIVE, WAKE_BUSY}, {~m[3], ~m[2], m[1], 2'b10});
      wr(ADDR_PWR_CTL, 8'h00);
      check({SLEEP_ACTIVE, BANDGAP_OFF, WAKE_BUSY}, 3'b001);
      wake_len(n);
      p = m[1] ? 185 : 35;
      check(32'(n >= p && n <= p + 15), 1);
    end
    // Pin as sleep request, then as sync source
    SHARED_SYNC_SLEEP_PIN = 1'b1;
    tick(3);
    check({SLEEP_ACTIVE, SYNC_PULSE}, 2'b10);
    SHARED_SYNC_SLEEP_PIN = 1'b0;
    tick(3);
    wake_len(n);
    wr(ADDR_SYNC_REF, 8'h80);
    p = pulses;
    SHARED_SYNC_SLEEP_PIN = 1'b1;
    tick(4);
    check({SLEEP_ACTIVE, 8'(pulses - p)}, 9'h001);
    SHARED_SYNC_SLEEP_PIN = 1'b0;
    // Register sync: needs enable, fires on 0->1 only
    foreach (syncs[k]) begin
      m = syncs[k];
      p = pulses;
      wr(ADDR_SYNC_REF, m);
      check(pulses - p, 32'(k == 2 || k == 5));
    end
    rd_chk(ADDR_SYNC_REF, 8'h60);
    // Reference select codes, all four passed through
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SYNC_REF, {4'h0, 1'b1, 2'(c), 1'b1});
      check({REFERENCE_SOURCE_BY_REGISTER, REFERENCE_SELECT,
             SINGLE_ENDED_CLOCK_SELECT}, {1'b1, 2'(c), 1'b1});
    end
    finish_test();
  end
endmodule : output_buffer_power_down_regs_tb
